// File: mem_if_params.svh
`ifndef MEM_IF_PARAMS_SVH
`define MEM_IF_PARAMS_SVH
// ****************************************
// timing
// ****************************************
`define CLK_PERIOD_NS 10
`define T_SHORT_NS 30
`define T_LONG_NS 60
`define T_STEP_NS 30
`define T_FLOAT_NS 15
`define T_RD_EXTRA_NS 30
`define XTAL_REF_PERIODS 512
// ****************************************
// register indices, byte address is index * 4
// ****************************************
`define IDX_CONFIG 8'h32
`define IDX_BASE 8'h34
`define IDX_QSIZE 8'h36
`define IDX_BUSCTL 8'h40
`define IDX_STATUS 8'h41
`define RST_CONFIG 16'he400
`define RST_ZERO16 16'h0000
`define RST_ZERO8 8'h00
`define RST_BUSCTL 1'b0
// ****************************************
// field positions
// ****************************************
`define CF_REF 0
`define CF_ORG_LO 1
`define CF_UV_LO 4
`define CF_WZ_LO 6
`define CF_PRIO_LO 8
`define QS_CS_LO 0
`define QS_MS_LO 2
`define QS_HS_LO 5
// ****************************************
// queue layout and dram geometry
// ****************************************
`define QUEUE_OFS 24'h000100
`define BASE_PAD 8'h00
`define QSTEP_WORDS 11'h080
`define CI_STEP_WORDS 11'h040
`define ROWS_256K 11'h1ff
`define ROWS_1M 11'h3ff
`define ROWS_4M 11'h7ff
`define COLB_256K 4'h9
`define COLB_1M 4'ha
`define COLB_4M 4'hb
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// File: mem_if_pkg.sv
`default_nettype none
package mem_if_pkg;
	typedef enum logic [2:0] {
		ORG_SRAM_128K = 3'h0,
		ORG_SRAM_512K = 3'h1,
		ORG_DRAM_256K = 3'h2,
		ORG_DRAM_1M = 3'h3,
		ORG_DRAM_4M = 3'h4
	} mem_org_t;
	typedef enum logic [1:0] {
		REQ_RX_DMA = 2'h0,
		REQ_CPU = 2'h1,
		REQ_TX_DMA = 2'h2,
		REQ_IRQ_CTRL = 2'h3
	} requester_code_t;
	typedef enum logic [2:0] {
		SEL_NONE = 3'h0,
		SEL_CFG = 3'h1,
		SEL_BASE = 3'h2,
		SEL_QSZ = 3'h3,
		SEL_BUSCTL = 3'h4,
		SEL_STAT = 3'h5
	} reg_sel_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_CYCLE = 2'b10
	} mem_state_t;
endpackage : mem_if_pkg
`default_nettype wire

// File: refresh_timer.sv
`include "mem_if_params.svh"
`default_nettype none
module refresh_timer #(
	parameter int unsigned PERIODS = `XTAL_REF_PERIODS
) (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic rstn_in,
	// crystal pin, asynchronous to clk_sys_in
	input wire logic crystal_clock_in,
	// control
	input wire logic enable_in,
	input wire logic served_in,
	// request
	output logic pending_out,
	output logic urgent_out
);
	localparam int unsigned CW = $clog2(PERIODS);
	logic xs1_r, xs2_r, xs3_r;
	logic [CW-1:0] cnt_r;
	logic pend_r, urg_r;
	// crystal edge seen after the two-flop synchroniser
	wire x_rise = xs2_r & ~xs3_r;
	wire wrap = x_rise && (cnt_r == CW'(PERIODS - 1));
	wire half = x_rise && (cnt_r == CW'(PERIODS / 2 - 1));
	assign pending_out = pend_r;
	assign urgent_out = urg_r;
	// synchroniser, first stage feeds only the second
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			xs1_r <= 1'b0;
			xs2_r <= 1'b0;
			xs3_r <= 1'b0;
		end else begin
			xs1_r <= crystal_clock_in;
			xs2_r <= xs1_r;
			xs3_r <= xs2_r;
		end
	end
	// period counter, one request per full period
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cnt_r <= '0;
			pend_r <= 1'b0;
			urg_r <= 1'b0;
		end else if (!enable_in) begin
			cnt_r <= '0;
			pend_r <= 1'b0;
			urg_r <= 1'b0;
		end else begin
			if (x_rise) begin
				cnt_r <= wrap ? '0 : cnt_r + CW'(1);
			end
			// a new period wins over a grant in the same cycle
			if (wrap) begin
				pend_r <= 1'b1;
				urg_r <= pend_r && !served_in;
			end else if (served_in) begin
				pend_r <= 1'b0;
				urg_r <= 1'b0;
			end else if (half && pend_r) begin
				urg_r <= 1'b1;
			end
		end
	end
endmodule : refresh_timer
`default_nettype wire

// File: shared_memory_interface.sv
// Design decision made here: the AXI4-Lite slave port.
`include "mem_if_params.svh"
`default_nettype none
module shared_memory_interface #(
	parameter int unsigned AW = 12
) (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic rstn_in,
	input wire logic crystal_clock_in,
	// axi4-lite slave
	input wire logic [AW-1:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [AW-1:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	// requesters, indexed by requester code
	input wire logic [3:0] req_in,
	input wire logic [3:0] req_write_in,
	input wire logic [3:0] req_byte_in,
	input wire logic [95:0] req_addr_in,
	input wire logic [63:0] req_wdata_in,
	output logic [3:0] grant_out,
	output logic [3:0] done_out,
	output logic [15:0] req_rdata_out,
	// memory pins
	output logic [22:0] mem_addr_out,
	output logic [15:0] mem_data_out,
	input wire logic [15:0] mem_data_in,
	output logic mem_data_oe_out,
	output logic mem_ctrl_oe_out,
	output logic row_strobe_n_out,
	output logic col_strobe_n_out,
	output logic chip_sel_n_out,
	output logic out_en_n_out,
	output logic write_en_n_out,
	output logic [1:0] byte_en_n_out,
	// queue layout
	output logic [23:0] init_block_base_out,
	output logic [23:0] hdlc_queue_base_out,
	output logic [23:0] monitor_queue_base_out,
	output logic [23:0] ci_queue_base_out,
	output logic [10:0] hdlc_queue_words_out,
	output logic [10:0] monitor_queue_words_out,
	output logic [10:0] ci_queue_words_out
);
	localparam int unsigned CW = 6;
	localparam int unsigned P = `CLK_PERIOD_NS;
	// least times round up to whole cycles
	function automatic logic [CW-1:0] cyc_of(input int unsigned ns);
		return CW'((ns + P - 1) / P);
	endfunction : cyc_of
	localparam logic [CW-1:0] C_SHORT = cyc_of(`T_SHORT_NS);
	localparam logic [CW-1:0] C_LONG = cyc_of(`T_LONG_NS);
	localparam logic [CW-1:0] C_FLOAT = cyc_of(`T_FLOAT_NS);
	localparam logic [CW-1:0] C_RDX = cyc_of(`T_RD_EXTRA_NS);
	localparam logic [CW-1:0] C_RDPRE = C_RDX - C_FLOAT;

	function automatic mem_if_pkg::reg_sel_t reg_decode(input logic [AW-1:0] a);
		if (a[1:0] != 2'b00) return mem_if_pkg::SEL_NONE;
		if (a[AW-1:2] == (AW-2)'(`IDX_CONFIG)) return mem_if_pkg::SEL_CFG;
		if (a[AW-1:2] == (AW-2)'(`IDX_BASE)) return mem_if_pkg::SEL_BASE;
		if (a[AW-1:2] == (AW-2)'(`IDX_QSIZE)) return mem_if_pkg::SEL_QSZ;
		if (a[AW-1:2] == (AW-2)'(`IDX_BUSCTL)) return mem_if_pkg::SEL_BUSCTL;
		if (a[AW-1:2] == (AW-2)'(`IDX_STATUS)) return mem_if_pkg::SEL_STAT;
		return mem_if_pkg::SEL_NONE;
	endfunction : reg_decode

	function automatic logic [15:0] merge16(input logic [15:0] o, input logic [15:0] n,
			input logic [1:0] s);
		return {s[1] ? n[15:8] : o[15:8], s[0] ? n[7:0] : o[7:0]};
	endfunction : merge16

	// ****************************************
	// register file over axi4-lite
	// ****************************************
	logic [15:0] memory_if_config_r;
	logic [15:0] init_block_base_reg_r;
	logic [7:0] irq_queue_size_cfg_r;
	logic bus_hold_low_z_r;
	logic aw_got_r, w_got_r, bvalid_r, rvalid_r;
	logic [AW-1:0] aw_addr_r;
	logic [15:0] w_data_r;
	logic [1:0] w_strb_r, bresp_r, rresp_r;
	logic [31:0] rdata_r;
	logic [15:0] status_w, rd_val;
	mem_if_pkg::reg_sel_t wr_sel, rd_sel;

	assign s_axi_awready_out = !aw_got_r && !bvalid_r;
	assign s_axi_wready_out = !w_got_r && !bvalid_r;
	assign s_axi_bvalid_out = bvalid_r;
	assign s_axi_bresp_out = bresp_r;
	assign s_axi_arready_out = !rvalid_r;
	assign s_axi_rvalid_out = rvalid_r;
	assign s_axi_rdata_out = rdata_r;
	assign s_axi_rresp_out = rresp_r;
	// write fires once both halves are held
	wire do_write = aw_got_r && w_got_r && !bvalid_r;
	wire rd_go = s_axi_arvalid_in && !rvalid_r;
	assign wr_sel = reg_decode(aw_addr_r);
	assign rd_sel = reg_decode(s_axi_araddr_in);
	assign rd_val = (rd_sel == mem_if_pkg::SEL_CFG) ? memory_if_config_r :
		(rd_sel == mem_if_pkg::SEL_BASE) ? init_block_base_reg_r :
		(rd_sel == mem_if_pkg::SEL_QSZ) ? {`RST_ZERO8, irq_queue_size_cfg_r} :
		(rd_sel == mem_if_pkg::SEL_BUSCTL) ? {15'h0000, bus_hold_low_z_r} :
		(rd_sel == mem_if_pkg::SEL_STAT) ? status_w : `RST_ZERO16;

	// address and data may arrive in either order
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			aw_addr_r <= '0;
			w_data_r <= `RST_ZERO16;
			w_strb_r <= 2'b00;
		end else begin
			if (s_axi_awvalid_in && s_axi_awready_out) begin
				aw_got_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr_in;
			end else if (do_write) begin
				aw_got_r <= 1'b0;
			end
			if (s_axi_wvalid_in && s_axi_wready_out) begin
				w_got_r <= 1'b1;
				w_data_r <= s_axi_wdata_in[15:0];
				w_strb_r <= s_axi_wstrb_in[1:0];
			end else if (do_write) begin
				w_got_r <= 1'b0;
			end
		end
	end

	// responses; unmapped addresses answer slverr
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			bvalid_r <= 1'b0;
			bresp_r <= `RESP_OKAY;
			rvalid_r <= 1'b0;
			rresp_r <= `RESP_OKAY;
			rdata_r <= 32'h0000_0000;
		end else begin
			if (do_write) begin
				bvalid_r <= 1'b1;
				bresp_r <= (wr_sel == mem_if_pkg::SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
			end else if (s_axi_bready_in) begin
				bvalid_r <= 1'b0;
			end
			if (rd_go) begin
				rvalid_r <= 1'b1;
				rdata_r <= {16'h0000, rd_val};
				rresp_r <= (rd_sel == mem_if_pkg::SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
			end else if (s_axi_rready_in) begin
				rvalid_r <= 1'b0;
			end
		end
	end

	// register storage; status is read only, reserved bits read zero
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			memory_if_config_r <= `RST_CONFIG;
			init_block_base_reg_r <= `RST_ZERO16;
			irq_queue_size_cfg_r <= `RST_ZERO8;
			bus_hold_low_z_r <= `RST_BUSCTL;
		end else if (do_write) begin
			case (wr_sel)
				mem_if_pkg::SEL_CFG: begin
					memory_if_config_r <= merge16(memory_if_config_r, w_data_r, w_strb_r);
				end
				mem_if_pkg::SEL_BASE: begin
					init_block_base_reg_r <= merge16(init_block_base_reg_r, w_data_r, w_strb_r);
				end
				mem_if_pkg::SEL_QSZ: begin
					if (w_strb_r[0]) irq_queue_size_cfg_r <= w_data_r[7:0];
				end
				mem_if_pkg::SEL_BUSCTL: begin
					if (w_strb_r[0]) bus_hold_low_z_r <= w_data_r[0];
				end
				default: begin
				end
			endcase
		end
	end

	// ****************************************
	// configuration decode
	// ****************************************
	wire [15:0] cfg = memory_if_config_r;
	wire [2:0] org = cfg[`CF_ORG_LO +: 3];
	// codes above 4 are forbidden; treated as sram
	wire dram = (org == mem_if_pkg::ORG_DRAM_256K) || (org == mem_if_pkg::ORG_DRAM_1M) ||
		(org == mem_if_pkg::ORG_DRAM_4M);
	wire [3:0] colb = (org == mem_if_pkg::ORG_DRAM_256K) ? `COLB_256K :
		(org == mem_if_pkg::ORG_DRAM_1M) ? `COLB_1M : `COLB_4M;
	wire [10:0] row_max = (org == mem_if_pkg::ORG_DRAM_256K) ? `ROWS_256K :
		(org == mem_if_pkg::ORG_DRAM_1M) ? `ROWS_1M : `ROWS_4M;
	wire [CW-1:0] tu = cfg[`CF_UV_LO] ? C_LONG : C_SHORT;
	wire [CW-1:0] tv = cfg[`CF_UV_LO + 1] ? C_LONG : C_SHORT;
	wire [CW-1:0] tw = cfg[`CF_WZ_LO] ? C_LONG : C_SHORT;
	wire [CW-1:0] tz = cfg[`CF_WZ_LO + 1] ? C_LONG : C_SHORT;
	wire [CW-1:0] tuv = cyc_of(`T_STEP_NS * (32'(cfg[`CF_UV_LO +: 2]) + 1));
	wire [CW-1:0] twz = cyc_of(`T_STEP_NS * (32'(cfg[`CF_WZ_LO +: 2]) + 1));

	// ****************************************
	// arbitration
	// ****************************************
	logic ref_pending, ref_urgent;
	logic [1:0] prio_code [4];
	logic [3:0] hit;
	mem_if_pkg::mem_state_t state_r, state_nxt;
	genvar k;
	generate
		for (k = 0; k < 4; k++) begin : g_prio
			assign prio_code[k] = cfg[`CF_PRIO_LO + 2 * k +: 2];
			assign hit[k] = req_in[prio_code[k]];
		end
	endgenerate
	wire any_hit = |hit;
	wire [1:0] pick = hit[0] ? prio_code[0] : hit[1] ? prio_code[1] :
		hit[2] ? prio_code[2] : prio_code[3];
	// refresh is fifth unless it has waited half a period
	wire ref_go = ref_pending && (ref_urgent || !any_hit);
	wire idle = (state_r == mem_if_pkg::ST_IDLE);
	wire start = idle && (any_hit || ref_go);
	wire sel_wr = req_write_in[pick] && !ref_go;

	refresh_timer #(
		.PERIODS(`XTAL_REF_PERIODS)
	) u_refresh (
		.clk_sys_in(clk_sys_in),
		.rstn_in(rstn_in),
		.crystal_clock_in(crystal_clock_in),
		.enable_in(cfg[`CF_REF] && dram),
		.served_in(start && ref_go),
		.pending_out(ref_pending),
		.urgent_out(ref_urgent)
	);

	// phase boundaries for the cycle about to start
	wire [CW-1:0] b1_c = dram ? tu : sel_wr ? C_FLOAT : C_RDPRE;
	wire [CW-1:0] b2_c = dram ? tu + tv : b1_c;
	wire [CW-1:0] b3_c = dram ? tu + tv + tw : b1_c + (sel_wr ? tuv : twz);
	wire [CW-1:0] tot_c = dram ? b3_c + tz : sel_wr ? b3_c + C_FLOAT : twz + C_RDX;

	// ****************************************
	// memory cycle
	// ****************************************
	logic [CW-1:0] el_r, b1_r, b2_r, b3_r, tot_r;
	logic cur_ref_r, cur_wr_r, cur_byte_r, cur_dram_r;
	logic [1:0] cur_code_r;
	logic [23:0] cur_addr_r;
	logic [15:0] cur_wdata_r, rdata_r2, data_s1_r, data_s2_r;
	logic [10:0] ref_row_r;
	logic [3:0] done_r;
	wire in_cyc = (state_r == mem_if_pkg::ST_CYCLE);
	wire last = in_cyc && (el_r == tot_r - CW'(1));
	wire float_w = in_cyc && (el_r >= tot_r - C_FLOAT);
	wire ph1 = el_r >= b1_r;
	wire ph2 = (el_r >= b2_r) && (el_r < b3_r);
	wire ph13 = ph1 && (el_r < b3_r);

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			mem_if_pkg::ST_IDLE: begin
				if (start) state_nxt = mem_if_pkg::ST_CYCLE;
			end
			mem_if_pkg::ST_CYCLE: begin
				if (last) state_nxt = mem_if_pkg::ST_IDLE;
			end
			default: begin
				state_nxt = mem_if_pkg::ST_IDLE;
			end
		endcase
	end

	// cycle setup is latched so config writes cannot cut a cycle
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state_r <= mem_if_pkg::ST_IDLE;
			el_r <= '0;
			{b1_r, b2_r, b3_r, tot_r} <= '0;
			{cur_ref_r, cur_wr_r, cur_byte_r, cur_dram_r} <= 4'h0;
			cur_code_r <= 2'b00;
			cur_addr_r <= 24'h000000;
			cur_wdata_r <= `RST_ZERO16;
		end else begin
			state_r <= state_nxt;
			el_r <= in_cyc ? el_r + CW'(1) : '0;
			if (start) begin
				{b1_r, b2_r, b3_r, tot_r} <= {b1_c, b2_c, b3_c, tot_c};
				{cur_ref_r, cur_wr_r, cur_dram_r} <= {ref_go, sel_wr, dram};
				cur_byte_r <= req_byte_in[pick] && !ref_go;
				cur_code_r <= pick;
				cur_addr_r <= req_addr_in[pick * 24 +: 24];
				cur_wdata_r <= req_wdata_in[pick * 16 +: 16];
			end
		end
	end

	// read data passes two flops; captured at strobe rise
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			data_s1_r <= `RST_ZERO16;
			data_s2_r <= `RST_ZERO16;
			rdata_r2 <= `RST_ZERO16;
			done_r <= 4'h0;
			ref_row_r <= 11'h000;
		end else begin
			data_s1_r <= mem_data_in;
			data_s2_r <= data_s1_r;
			if (in_cyc && !cur_wr_r && !cur_ref_r && el_r == b3_r) rdata_r2 <= data_s2_r;
			done_r <= (last && !cur_ref_r) ? 4'h1 << cur_code_r : 4'h0;
			if (last && cur_ref_r) begin
				ref_row_r <= (ref_row_r >= row_max) ? 11'h000 : ref_row_r + 11'h001;
			end
		end
	end

	assign grant_out = (in_cyc && !cur_ref_r) ? 4'h1 << cur_code_r : 4'h0;
	assign done_out = done_r;
	assign req_rdata_out = rdata_r2;

	// ****************************************
	// pin drive
	// ****************************************
	wire [22:0] waddr = cur_addr_r[23:1];
	wire [22:0] d_row = waddr >> colb;
	wire [22:0] d_col = waddr & ((23'h000001 << colb) - 23'h000001);
	wire sram_c = in_cyc && !cur_dram_r;
	wire dram_c = in_cyc && cur_dram_r;
	// outside cycles the hold bit decides whether the bus stays driven
	assign mem_ctrl_oe_out = in_cyc ? !float_w : bus_hold_low_z_r;
	assign mem_data_oe_out = in_cyc ? (cur_wr_r && !float_w) : bus_hold_low_z_r;
	assign mem_data_out = cur_wdata_r;
	assign mem_addr_out = cur_ref_r ? {12'h000, ref_row_r} :
		!cur_dram_r ? waddr : (el_r < b2_r) ? d_row : d_col;
	assign row_strobe_n_out = !(dram_c && ph1);
	assign col_strobe_n_out = !(dram_c && !cur_ref_r && ph2);
	assign chip_sel_n_out = !(sram_c && ph13);
	assign out_en_n_out = !(in_cyc && !cur_wr_r && !cur_ref_r &&
		(cur_dram_r ? ph2 : ph13));
	assign write_en_n_out = !(in_cyc && cur_wr_r && (cur_dram_r ? ph2 : ph13));
	assign byte_en_n_out = !cur_byte_r ? 2'b00 : cur_addr_r[0] ? 2'b01 : 2'b10;

	// ****************************************
	// queue layout and status
	// ****************************************
	wire [23:0] base_w = {init_block_base_reg_r, `BASE_PAD};
	wire [10:0] hq_w = `QSTEP_WORDS * (11'(irq_queue_size_cfg_r[`QS_HS_LO +: 3]) + 11'h001);
	wire [10:0] mq_w = `QSTEP_WORDS * (11'(irq_queue_size_cfg_r[`QS_MS_LO +: 3]) + 11'h001);
	wire [10:0] cq_w = `CI_STEP_WORDS * (11'(irq_queue_size_cfg_r[`QS_CS_LO +: 2]) + 11'h001);
	assign status_w = {10'h000, cur_code_r, ref_urgent, ref_pending, cur_ref_r, in_cyc};

	// queue bases in bytes, each word being two bytes
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			init_block_base_out <= 24'h000000;
			hdlc_queue_base_out <= 24'h000000;
			monitor_queue_base_out <= 24'h000000;
			ci_queue_base_out <= 24'h000000;
			{hdlc_queue_words_out, monitor_queue_words_out, ci_queue_words_out} <= '0;
		end else begin
			init_block_base_out <= base_w;
			hdlc_queue_base_out <= base_w + `QUEUE_OFS;
			monitor_queue_base_out <= base_w + `QUEUE_OFS + {12'h000, hq_w, 1'b0};
			ci_queue_base_out <= base_w + `QUEUE_OFS + {12'h000, hq_w, 1'b0} +
				{12'h000, mq_w, 1'b0};
			hdlc_queue_words_out <= hq_w;
			monitor_queue_words_out <= mq_w;
			ci_queue_words_out <= cq_w;
		end
	end
endmodule : shared_memory_interface
`default_nettype wire

// File: mem_if_monitor.sv
`default_nettype none
module mem_if_monitor (
	// watched ports
	input wire logic clk_sys_in,
	input wire logic rstn_in,
	input wire logic [3:0] grant_out,
	input wire logic [3:0] done_out,
	input wire logic mem_ctrl_oe_out,
	input wire logic row_strobe_n_out,
	input wire logic col_strobe_n_out,
	input wire logic chip_sel_n_out,
	input wire logic out_en_n_out,
	input wire logic [23:0] init_block_base_out
);
	timeunit 1ns;
	timeprecision 100ps;
	// ****************************************
	// memory cycle checks
	// ****************************************
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!rstn_in);
	// arbitration: one owner, held two clocks after it rises, done names that owner
	one_grant_a: assert property ($onehot0(grant_out))
		else $error("more than one grant");
	grant_hold_a: assert property ($rose(|grant_out) |=> $stable(grant_out)[*2])
		else $error("grant changed inside a cycle");
	done_owner_a: assert property ((|done_out) |-> done_out == $past(grant_out))
		else $error("done does not match owner");
	// the tail of every requester cycle must be floated
	float_tail_a: assert property ((|done_out) |->
			!$past(mem_ctrl_oe_out) && !$past(mem_ctrl_oe_out, 2))
		else $error("pins driven in cycle tail");
	// dram phases are at least three clocks each
	ras_lead_a: assert property ($fell(row_strobe_n_out) |-> $past(mem_ctrl_oe_out, 3))
		else $error("row strobe fell too early");
	cas_after_ras_a: assert property ($fell(col_strobe_n_out) |-> !$past(row_strobe_n_out, 3))
		else $error("column strobe too close to row strobe");
	cas_width_a: assert property ($fell(col_strobe_n_out) |=> !col_strobe_n_out[*2])
		else $error("column strobe pulse too short");
	// sram strobes are at least three clocks low
	cs_width_a: assert property ($fell(chip_sel_n_out) |=> !chip_sel_n_out[*2])
		else $error("chip select pulse too short");
	oe_width_a: assert property ($fell(out_en_n_out) |=> !out_en_n_out[*2])
		else $error("output enable pulse too short");
	base_low_a: assert property (init_block_base_out[7:0] == 8'h00)
		else $error("init block base low byte set");
endmodule : mem_if_monitor
bind shared_memory_interface mem_if_monitor u_monitor (
	.clk_sys_in, .rstn_in, .grant_out, .done_out, .mem_ctrl_oe_out, .row_strobe_n_out,
	.col_strobe_n_out, .chip_sel_n_out, .out_en_n_out, .init_block_base_out
);
`default_nettype wire

// File: sram_model.sv
`default_nettype none
module sram_model (
	// memory pins seen from the chip
	input wire logic [22:0] addr_in,
	input wire logic [15:0] data_in,
	input wire logic data_oe_in,
	input wire logic chip_sel_n_in,
	input wire logic out_en_n_in,
	input wire logic write_en_n_in,
	output logic [15:0] data_out
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [15:0] mem [logic [22:0]];
	logic [15:0] last = 16'h0000;
	// store one word per address while the chip drives under a write strobe
	always @(*) begin
		if (!chip_sel_n_in && !write_en_n_in && data_oe_in) mem[addr_in] = data_in;
	end
	// released lines show the inverse of the last word, so a late sample cannot pass
	always @(*) begin
		if (!chip_sel_n_in && !out_en_n_in) begin
			data_out = mem.exists(addr_in) ? mem[addr_in] : 16'h0000;
			last = data_out;
		end else begin
			data_out = ~last;
		end
	end
endmodule : sram_model
`default_nettype wire

// File: tb.sv
`include "mem_if_params.svh"
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_sys_in = 0, rstn_in = 0, xtal = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
	logic [11:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata;
	logic awr, wr, bv, arr, rv, mdoe, coe, ras_n, cas_n, cs_n, oe_n, we_n;
	logic [1:0] bresp, rresp, ben;
	logic [3:0] req = 0, req_wr = 0, rbyte = 0, grant, done;
	logic [95:0] addr = 0;
	logic [63:0] wd = 0;
	logic [15:0] rd_data, mdo, mdi;
	logic [22:0] maddr;
	logic [23:0] ib, hb, mb, cb;
	logic [10:0] hw, mw, cw;
	int miscompares = 0, compares = 0, seed = 30326;
	// crystal runs free at an unrelated period
	always #5 clk_sys_in = ~clk_sys_in;
	always #16.3 xtal = ~xtal;
	shared_memory_interface DUT (
		.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .crystal_clock_in(xtal),
		.s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
		.s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wv),
		.s_axi_wready_out(wr), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv),
		.s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arv),
		.s_axi_arready_out(arr), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
		.s_axi_rvalid_out(rv), .s_axi_rready_in(rready), .req_in(req),
		.req_write_in(req_wr), .req_byte_in(rbyte), .req_addr_in(addr),
		.req_wdata_in(wd), .grant_out(grant), .done_out(done), .req_rdata_out(rd_data),
		.mem_addr_out(maddr), .mem_data_out(mdo), .mem_data_in(mdi),
		.mem_data_oe_out(mdoe), .mem_ctrl_oe_out(coe), .row_strobe_n_out(ras_n),
		.col_strobe_n_out(cas_n), .chip_sel_n_out(cs_n), .out_en_n_out(oe_n),
		.write_en_n_out(we_n), .byte_en_n_out(ben), .init_block_base_out(ib),
		.hdlc_queue_base_out(hb), .monitor_queue_base_out(mb), .ci_queue_base_out(cb),
		.hdlc_queue_words_out(hw), .monitor_queue_words_out(mw), .ci_queue_words_out(cw)
	);
	sram_model u_mem (
		.addr_in(maddr), .data_in(mdo), .data_oe_in(mdoe), .chip_sel_n_in(cs_n),
		.out_en_n_in(oe_n), .write_en_n_in(we_n), .data_out(mdi)
	);
	// ****************************************
	// helpers
	// ****************************************
	task automatic finish_test();
		$display("miscompares %0d compares %0d", miscompares, compares);
		if (miscompares == 0 && compares > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : finish_test
	task automatic chk(input logic [95:0] got, input logic [95:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: saw %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic hang();
		miscompares++;
		$display("Error at %0t: wait ran out", $time);
		finish_test();
	endtask : hang
	// one axi access; valids drop at their own handshake
	task automatic bus(input bit w, input logic [11:0] a, input logic [15:0] d,
			output logic [31:0] q, output logic [1:0] r);
		int n;
		@(posedge clk_sys_in);
		n = 0;
		awaddr <= a;
		araddr <= a;
		wdata <= {16'h0000, d};
		awv <= w;
		wv <= w;
		bready <= w;
		arv <= !w;
		rready <= !w;
		do begin
			@(posedge clk_sys_in);
			n++;
			if (awr) awv <= 1'b0;
			if (wr) wv <= 1'b0;
			if (arr) arv <= 1'b0;
		end while (!(w ? bv : rv) && n < 99);
		bready <= 1'b0;
		rready <= 1'b0;
		q = rdata;
		r = w ? bresp : rresp;
		if (n >= 99) hang();
	endtask : bus
	// memory requests; each one drops in its own done cycle
	task automatic mem(input logic [3:0] m, input bit w, input logic [23:0] a,
			input logic [15:0] d, output logic [3:0] first, output int ncs, output int out_en_n);
		int n;
		@(posedge clk_sys_in);
		first = 4'h0;
		ncs = 0;
		out_en_n = 0;
		n = 0;
		addr <= {4{a}};
		wd <= {4{d}};
		req_wr <= {4{w}};
		req <= m;
		do begin
			@(posedge clk_sys_in);
			#1;
			n++;
			if (first == 4'h0) first = grant;
			ncs += !cs_n;
			out_en_n += !oe_n;
			req <= req & ~done;
		end while ((req & ~done) != 4'h0 && n < 999);
		if (n >= 999) hang();
	endtask : mem
	// counts row strobe falls and the spacing of the last two
	task automatic ras_watch(input int cyc, output int k, output realtime dt);
		realtime t0;
		logic prev;
		prev = 1'b1;
		k = 0;
		t0 = 0;
		dt = 0;
		repeat (cyc) begin
			@(posedge clk_sys_in);
			#1;
			if (prev && !ras_n) begin
				dt = $realtime - t0;
				t0 = $realtime;
				k++;
			end
			prev = ras_n;
		end
	endtask : ras_watch
	// queue bases in bytes: each queue follows the one before it
	function automatic logic [95:0] layout(input logic [15:0] b, input logic [7:0] s);
		logic [23:0] h;
		logic [23:0] m;
		h = {b, 8'h00} + 24'h000100;
		m = h + 24'(s[7:5]) * 24'h000100 + 24'h000100;
		return {b, 8'h00, h, m, m + 24'(s[4:2]) * 24'h000100 + 24'h000100};
	endfunction : layout
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		logic [31:0] q;
		logic [1:0] r;
		logic [3:0] g;
		logic [15:0] v;
		logic [15:0] b;
		logic [7:0] s;
		int ncs, out_en_n, k;
		realtime dt;
		repeat (3) @(posedge clk_sys_in);
		rstn_in <= 1'b1;
		bus(0, 12'h0c8, 0, q, r);
		chk(q, `RST_CONFIG);
		bus(0, 12'h0d0, 0, q, r);
		chk(q, 0);
		bus(0, 12'h0c4, 0, q, r);
		chk({q, r}, `RESP_SLVERR);
		$display("reset values done");
		repeat (4) begin
			b = 16'($random(seed));
			s = 8'($random(seed));
			bus(1, 12'h0d0, b, q, r);
			bus(1, 12'h0d8, {8'h00, s}, q, r);
			chk(r, `RESP_OKAY);
			bus(0, 12'h0d8, 0, q, r);
			chk(q, s);
			chk({ib, hb, mb, cb}, layout(b, s));
			chk({hw, mw, cw}, {11'(s[7:5]) * 11'h080 + 11'h080,
				11'(s[4:2]) * 11'h080 + 11'h080, 11'(s[1:0]) * 11'h040 + 11'h040});
		end
		$display("queue layout done");
		for (int t = 0; t < 4; t++) begin
			v = 16'($random(seed));
			b = 16'($random(seed)) & 16'hfffe;
			bus(1, 12'h0c8, 16'he400 | 16'(t) * 16'h0050, q, r);
			mem(4'(1 << t), 1, {8'h00, b}, v, g, ncs, out_en_n);
			chk(ncs, 3 * t + 3);
			mem(4'(1 << t), 0, {8'h00, b}, 0, g, ncs, out_en_n);
			chk(out_en_n, 3 * t + 3);
			chk(rd_data, v);
		end
		// odd byte read: high lane enabled, word address drops the byte bit
		rbyte <= 4'h2;
		mem(4'h2, 0, 24'h000001, 0, g, ncs, out_en_n);
		chk({ben, maddr}, {2'b01, 23'h000000});
		rbyte <= 4'h0;
		// hold bit decides whether idle pins stay driven
		bus(1, 12'h100, 16'h0001, q, r);
		chk({coe, mdoe}, 2'b11);
		bus(1, 12'h100, 16'h0000, q, r);
		chk({coe, mdoe}, 2'b00);
		$display("sram timing done");
		mem(4'h9, 0, 24'h0, 0, g, ncs, out_en_n);
		chk(g, 4'h1);
		bus(1, 12'h0c8, 16'h1b00, q, r);
		mem(4'h9, 0, 24'h0, 0, g, ncs, out_en_n);
		chk(g, 4'h8);
		$display("priority done");
		bus(1, 12'h0c8, 16'he404, q, r);
		ras_watch(2000, k, dt);
		chk(k, 0);
		bus(1, 12'h0c8, 16'he4f5, q, r);
		mem(4'h4, 0, 24'h0, 0, g, ncs, out_en_n);
		ras_watch(5200, k, dt);
		chk({k >= 2, dt > 16661.0 && dt < 16721.0}, 2'b11);
		$display("refresh done");
		finish_test();
	end
endmodule : tb
`default_nettype wire
